// *** logic/acc_sample_buffer.sv ***
/*
 * Sample buffer control: 32-entry store, input gate across wake/sleep
 * changes, flush sources, triggered capture and auto wake/sleep sequencing.
 * Assumes register strobes, samples, output-rate ticks and trigger events
 * are synchronous one-cycle pulses on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

module acc_sample_buffer
  import acc_buf_pkg::*;
#(
  parameter int SAMPLE_W = 36
) (
  input  wire logic                     clk_sys,
  input  wire logic                     nrst,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  output var  logic [7:0]               reg_rdata,
  input  wire acc_buf_pkg::op_mode_type op_mode,
  input  wire logic [7:0]               auto_sleep_count,
  input  wire logic                     odr_tick,
  input  wire logic                     wake_request,
  input  wire logic                     sleep_block,
  input  wire acc_buf_pkg::trig_events_type trig_events,
  input  wire logic                     sample_valid,
  input  wire logic [SAMPLE_W-1:0]      sample_data,
  input  wire logic                     buf_pop,
  output var  logic [SAMPLE_W-1:0]      buf_data,
  output var  logic                     buf_data_valid,
  output var  acc_buf_pkg::pwr_type     power_mode,
  output var  logic                     overflow_flag,
  output var  logic                     watermark_flag,
  output var  logic [5:0]               sample_count,
  output var  logic                     gate_err,
  output var  logic [4:0]               gate_cnt
);
  import acc_buf_pkg::*;

  logic [SAMPLE_W-1:0] mem [BUF_DEPTH];
  cfg_one_type         cfg1_q;
  cfg_two_type         cfg2_q;
  pwr_type             pwr_q, pwr_d;
  trig_state_type      trig_q;
  logic [PTR_W-1:0]    wr_ptr_q, rd_ptr_q;
  logic [CNT_W-1:0]    cnt_q, cnt_d, post_q, wm, post_lim;
  logic [7:0]          tmr_q;
  logic                gate_closed_q, ovf_q, wm_q, err_q, dout_v_q;
  logic [4:0]          gcnt_q;
  logic [SAMPLE_W-1:0] dout_q;
  logic [7:0]          rdata_q;
  logic flush_cmd, disabled, trig_mode, aslp_on, gate_eff, stay_awake;
  logic leave_standby, ws_change, flush_all, gate_close, pop_ok, empty_evt;
  logic discard, trig_hit, trig_fire, do_wr, do_adv, ovf_set, post_done;

  // Decode the mode and the flush sources that act on the whole buffer.
  assign wm        = cfg2_q.watermark_level;
  assign disabled  = cfg1_q.mode == MODE_DISABLED;
  assign trig_mode = cfg1_q.mode == MODE_TRIG;
  assign aslp_on   = auto_sleep_count != 8'h00;
  assign flush_cmd = reg_wr && reg_addr == ADDR_CFG_TWO
                     && reg_wdata[FLUSH_BIT];
  assign gate_eff  = cfg1_q.gate_en && !(trig_mode && aslp_on);
  assign leave_standby = pwr_q == PWR_STANDBY && pwr_d != PWR_STANDBY;
  assign ws_change = pwr_q != PWR_STANDBY && pwr_d != PWR_STANDBY
                     && pwr_d != pwr_q;
  // Without an effective gate every rate change wipes the buffer except the wake
  // below, so only that wake lets samples at two output rates share it.
  // Triggered capture with auto-sleep keeps its pre-trigger samples when
  // the trigger wakes the part; only the drop into sleep flushes there.
  assign flush_all = flush_cmd || disabled || leave_standby
                     || (ws_change && !gate_eff
                         && !(trig_mode && aslp_on && pwr_d == PWR_WAKE));
  assign gate_close = ws_change && gate_eff;
  assign pop_ok     = buf_pop && cnt_q != '0;

  // Trigger sources gated by their enables; only an armed capture may fire, in sleep
  // when auto-sleep is on, so anything holding the part awake then blocks capture.
  assign trig_hit  = (trig_events.within_thresh  && cfg1_q.trig_within_thresh_en)
                  || (trig_events.outside_thresh && cfg1_q.trig_outside_thresh_en)
                  || (trig_events.orientation    && cfg1_q.trig_orientation_en);
  assign trig_fire = trig_mode && trig_q == TRIG_ARMED && trig_hit
                     && (pwr_q == PWR_SLEEP || !aslp_on);
  assign post_lim  = (wm >= DEPTH_CNT) ? '0 : DEPTH_CNT - wm;
  assign stay_awake = sleep_block
                   || (trig_mode && trig_q != TRIG_ARMED)
                   || (cfg2_q.wake_src_buf && !trig_mode && (wm_q || ovf_q));

  // Auto wake/sleep sequencing: wake at once on leaving standby.
  always_comb begin
    pwr_d = pwr_q;
    if (op_mode == OP_STANDBY) begin
      pwr_d = PWR_STANDBY;
    end else begin
      case (pwr_q)
        PWR_STANDBY: pwr_d = PWR_WAKE;
        PWR_WAKE: begin
          if (aslp_on && !stay_awake && odr_tick
              && tmr_q + 8'h01 >= auto_sleep_count) begin
            pwr_d = PWR_SLEEP;
          end
        end
        PWR_SLEEP: begin
          if (!aslp_on || wake_request || trig_fire) begin
            pwr_d = PWR_WAKE;
          end
        end
        default: pwr_d = PWR_STANDBY;
      endcase
    end
  end

  // Storage decisions per collection mode for the arriving sample.
  always_comb begin
    do_wr   = 1'b0;
    do_adv  = pop_ok;
    ovf_set = 1'b0;
    post_done = 1'b0;
    discard = sample_valid && gate_closed_q && !flush_all;
    if (sample_valid && !flush_all && !gate_closed_q
        && pwr_q != PWR_STANDBY) begin
      case (cfg1_q.mode)
        MODE_STREAM: begin
          do_wr = 1'b1;
          if (cnt_q == DEPTH_CNT && !pop_ok) begin
            do_adv  = 1'b1;          // Oldest sample is overwritten.
            ovf_set = 1'b1;
          end
        end
        MODE_STOP: begin
          do_wr   = cnt_q != DEPTH_CNT || pop_ok;
          ovf_set = cnt_q == DEPTH_CNT && !pop_ok;
        end
        MODE_TRIG: begin
          if (trig_q == TRIG_ARMED && !trig_fire) begin
            do_wr = wm != '0;
            if (wm != '0 && cnt_q >= wm && !pop_ok) begin
              do_adv = 1'b1;
            end
          end else if (trig_q != TRIG_DONE && post_lim != '0) begin
            do_wr = 1'b1;
            post_done = (trig_q == TRIG_ARMED ? 6'h00 : post_q) + 6'h01
                        >= post_lim;
          end
        end
        default: do_wr = 1'b0;
      endcase
    end
    cnt_d = cnt_q + {5'h00, do_wr} - {5'h00, do_adv};
  end

  assign empty_evt = pop_ok && cnt_q == 6'h01 && !do_wr;

  // Configuration registers; the flush bit is never stored.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg1_q <= CFG_ONE_RESET;
      cfg2_q <= CFG_TWO_RESET;
    end else if (reg_wr && reg_addr == ADDR_CFG_ONE) begin
      cfg1_q <= reg_wdata;
    end else if (reg_wr && reg_addr == ADDR_CFG_TWO) begin
      cfg2_q <= {1'b0, reg_wdata[6:0]};
    end
  end

  // Power state and the auto-sleep period counter.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pwr_q <= PWR_STANDBY;
      tmr_q <= 8'h00;
    end else begin
      pwr_q <= pwr_d;
      if (pwr_d != PWR_WAKE || pwr_q != PWR_WAKE || stay_awake) begin
        tmr_q <= 8'h00;
      end else if (odr_tick) begin
        tmr_q <= tmr_q + 8'h01;
      end
    end
  end

  // Pointers and count; any flush restarts both pointers at zero.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else if (flush_all) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else begin
      if (do_wr) wr_ptr_q <= wr_ptr_q + 5'h01;
      if (do_adv) rd_ptr_q <= rd_ptr_q + 5'h01;
      cnt_q <= cnt_d;
    end
  end

  // Sample store; contents need no reset since the count guards them.
  always_ff @(posedge clk_sys) begin
    if (do_wr && !flush_all) mem[wr_ptr_q] <= sample_data;
  end

  // Read port toward the host.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dout_q   <= '0;
      dout_v_q <= 1'b0;
    end else begin
      dout_v_q <= pop_ok && !flush_all;
      if (pop_ok && !flush_all) dout_q <= mem[rd_ptr_q];
    end
  end

  // Overflow and watermark flags; a new overflow beats a same-cycle clear.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ovf_q <= 1'b0;
      wm_q  <= 1'b0;
    end else begin
      if (ovf_set || post_done) ovf_q <= 1'b1;
      else if (flush_all || empty_evt) ovf_q <= 1'b0;
      wm_q <= !flush_all && wm != '0 && cnt_d >= wm;
    end
  end

  // Input gate with its error flag and discard count. A discard in the
  // clearing cycle still wins so the host never misses a lost sample.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gate_closed_q <= 1'b0;
      err_q         <= 1'b0;
      gcnt_q        <= '0;
    end else begin
      if (gate_close) gate_closed_q <= 1'b1;
      else if (flush_all || empty_evt || cnt_q == '0) begin
        gate_closed_q <= 1'b0;
      end
      if (discard) begin
        err_q <= 1'b1;
        if (gcnt_q != GATE_CNT_MAX) gcnt_q <= gcnt_q + 5'h01;
      end else if (flush_all || empty_evt) begin
        err_q  <= 1'b0;
        gcnt_q <= '0;
      end
    end
  end

  // Triggered capture progress; empty or flush re-arms.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      trig_q <= TRIG_ARMED;
      post_q <= '0;
    end else if (flush_all || empty_evt || !trig_mode) begin
      trig_q <= TRIG_ARMED;
      post_q <= '0;
    end else begin
      case (trig_q)
        TRIG_ARMED: begin
          if (trig_fire) begin
            trig_q <= post_done || post_lim == '0 ? TRIG_DONE : TRIG_POST;
            post_q <= {5'h00, do_wr};
          end
        end
        TRIG_POST: begin
          if (post_done) trig_q <= TRIG_DONE;
          if (do_wr) post_q <= post_q + 6'h01;
        end
        TRIG_DONE: trig_q <= TRIG_DONE;
        default:   trig_q <= TRIG_ARMED;
      endcase
    end
  end

  // Register read data, captured on the read strobe.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_CFG_ONE:    rdata_q <= cfg1_q;
        ADDR_CFG_TWO:    rdata_q <= cfg2_q;
        ADDR_SYSTEM_MODE_STATUS:   rdata_q <= {err_q, gcnt_q, 2'(pwr_q)};
        ADDR_BUF_STATUS: rdata_q <= {ovf_q, wm_q, cnt_q};
        default:         rdata_q <= 8'h00;
      endcase
    end
  end

  assign reg_rdata      = rdata_q;
  assign buf_data       = dout_q;
  assign buf_data_valid = dout_v_q;
  assign power_mode     = pwr_q;
  assign overflow_flag  = ovf_q;
  assign watermark_flag = wm_q;
  assign sample_count   = cnt_q;
  assign gate_err       = err_q;
  assign gate_cnt       = gcnt_q;

  // Checks beside the logic they guard.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_flush_cmd_empties: assert property (flush_cmd |=> cnt_q == '0
    && !ovf_q && !err_q) else $error("flush command left buffer state");
  a_flush_reads_zero: assert property (reg_rd
    && reg_addr == ADDR_CFG_TWO |=> !reg_rdata[FLUSH_BIT])
    else $error("flush bit read as set");
  a_disable_clears: assert property (disabled |=> cnt_q == '0
    && !ovf_q && !wm_q && gcnt_q == '0) else $error("disable left flags");
  a_gate_discards: assert property (gate_closed_q && sample_valid
    && !flush_all && !buf_pop |=> err_q && $stable(cnt_q))
    else $error("closed gate stored a sample");
  a_gate_count_step: assert property (discard && gcnt_q < 5'h1e
    |=> gcnt_q == $past(gcnt_q) + 5'h01)
    else $error("discard count did not step");
  a_gate_err_held: assert property (err_q && !flush_all
    && !empty_evt |=> err_q) else $error("gate error dropped early");
  a_trig_ignores_gate: assert property (trig_mode && aslp_on
    && ws_change && pwr_d == PWR_SLEEP |=> cnt_q == '0 && wr_ptr_q == '0)
    else $error("no flush on change");
  a_standby_flush: assert property (leave_standby |=> cnt_q == '0
    && pwr_q == PWR_WAKE) else $error("standby exit not flushed");
  a_post_stays_wake: assert property (trig_mode
    && trig_q != TRIG_ARMED && pwr_q == PWR_WAKE && op_mode != OP_STANDBY
    |=> pwr_q == PWR_WAKE) else $error("left wake after trigger");
  a_gate_close_keeps: assert property (gate_close && !flush_all
    && cnt_q > 6'h01 && !buf_pop && !sample_valid
    |=> gate_closed_q && cnt_q == $past(cnt_q))
    else $error("gated change lost contents");

  c_trig_fire: cover property (trig_fire);
  c_trig_full: cover property (trig_q == TRIG_POST ##1 trig_q == TRIG_DONE);
  c_gate_discard: cover property (discard ##1 err_q);
  c_stream_ovf: cover property (cfg1_q.mode == MODE_STREAM && ovf_set);

endmodule

`default_nettype wire

// *** common/acc_buf_pkg.sv ***
/*
 * Shared constants and types for the accelerometer sample buffer control.
 * Assumes one system clock; the serial register interface in front of this
 * block hands over single byte reads and writes as one-cycle strobes.
 */
package acc_buf_pkg;

  // Buffer geometry.
  localparam int          BUF_DEPTH  = 32;
  localparam int          PTR_W      = 5;
  localparam int          CNT_W      = 6;
  localparam logic [5:0]  DEPTH_CNT  = 6'h20;
  localparam int          GATE_CNT_W = 5;
  localparam logic [4:0]  GATE_CNT_MAX = 5'h1f;

  // Register offsets.
  localparam logic [7:0]  ADDR_CFG_ONE    = 8'h26;
  localparam logic [7:0]  ADDR_CFG_TWO    = 8'h27;
  localparam logic [7:0]  ADDR_SYSTEM_MODE_STATUS   = 8'h14;
  localparam logic [7:0]  ADDR_BUF_STATUS = 8'h0b;

  // Reset values and field positions.
  localparam logic [7:0]  CFG_ONE_RESET = 8'h00;
  localparam logic [7:0]  CFG_TWO_RESET = 8'h00;
  localparam int          FLUSH_BIT     = 7;

  // Collection mode encoding.
  typedef enum logic [1:0] {
    MODE_DISABLED = 2'b00,
    MODE_STREAM   = 2'b01,
    MODE_STOP     = 2'b10,
    MODE_TRIG     = 2'b11
  } coll_mode_type;

  // Operating mode requested by the system controller.
  typedef enum logic [1:0] {
    OP_STANDBY  = 2'b00,
    OP_ACTIVE   = 2'b01,
    OP_EXTERNAL_TRIGGER_MODE = 2'b10
  } op_mode_type;

  // Power state of the auto wake/sleep function.
  typedef enum logic [1:0] {
    PWR_STANDBY,
    PWR_WAKE,
    PWR_SLEEP
  } pwr_type;

  // Triggered capture progress.
  typedef enum logic [1:0] {
    TRIG_ARMED,
    TRIG_POST,
    TRIG_DONE
  } trig_state_type;

  typedef struct packed {
    logic          read_lifo;
    coll_mode_type mode;
    logic          gate_en;
    logic          trig_within_thresh_en;
    logic          trig_outside_thresh_en;
    logic          spare;
    logic          trig_orientation_en;
  } cfg_one_type;

  typedef struct packed {
    logic       flush;
    logic       wake_src_buf;
    logic [5:0] watermark_level;
  } cfg_two_type;

  typedef struct packed {
    logic within_thresh;
    logic outside_thresh;
    logic orientation;
  } trig_events_type;

endpackage

// *** tb/acc_host_model.sv ***
/*
 * Host model: issues register writes, reads and buffer pops.
 * Assumes the block takes each strobe on a rising edge of clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module acc_host_model (
  input  wire logic        clk_sys,
  output var  logic        reg_wr,
  output var  logic        reg_rd,
  output var  logic [7:0]  reg_addr,
  output var  logic [7:0]  reg_wdata,
  input  wire logic [7:0]  reg_rdata,
  output var  logic        buf_pop,
  input  wire logic [35:0] buf_data,
  input  wire logic        buf_data_valid
);
  // Strobes idle low; released lines show a fresh pattern, not stale data.
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    buf_pop = 1'b0;
  end

  // One write, held across exactly one sampling edge.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // Read data is registered, so it is taken one edge after the strobe.
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask

  // Pop one sample; valid pulses one cycle after the accepted pop.
  task automatic pop(output logic [35:0] d, output logic v);
    @(posedge clk_sys);
    #1;
    buf_pop = 1'b1;
    @(posedge clk_sys);
    #1;
    buf_pop = 1'b0;
    d = buf_data;
    v = buf_data_valid;
  endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
/*
 * Self-checking bench for the sample buffer control.
 * Assumes the host model drives the register and pop strobes.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import acc_buf_pkg::*;
  logic            clk_sys, nrst, reg_wr, reg_rd, buf_pop, buf_data_valid;
  logic [7:0]      reg_addr, reg_wdata, reg_rdata, auto_sleep_count;
  op_mode_type     op_mode;
  logic            odr_tick, wake_request, sleep_block, sample_valid;
  trig_events_type trig_events;
  logic [35:0]     sample_data, buf_data;
  pwr_type         power_mode;
  logic            overflow_flag, watermark_flag, gate_err;
  logic [5:0]      sample_count;
  logic [4:0]      gate_cnt;
  int              errors, checks_done;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_type;
  row_type rows[5] = '{'{8'h26, 8'h0d, 8'h0d}, '{8'h26, 8'h00, 8'h00},
    '{8'h27, 8'hff, 8'h7f}, '{8'h27, 8'h05, 8'h05}, '{8'h30, 8'h5a, 8'h00}};

  acc_sample_buffer acc_sample_buffer_i (.clk_sys, .nrst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .op_mode, .auto_sleep_count,
    .odr_tick, .wake_request, .sleep_block, .trig_events, .sample_valid,
    .sample_data, .buf_pop, .buf_data, .buf_data_valid, .power_mode,
    .overflow_flag, .watermark_flag, .sample_count, .gate_err, .gate_cnt);
  acc_host_model acc_host_model_i (.clk_sys, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .buf_pop, .buf_data, .buf_data_valid);

  // Free-running 40 MHz clock.
  always #12.5 clk_sys = ~clk_sys;

  task automatic check(string n, logic [35:0] s, logic [35:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Extra cycle after each write, since effects land a cycle late.
  task automatic wr(logic [7:0] a, logic [7:0] d);
    acc_host_model_i.write_reg(a, d);
    cyc(1);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    logic [7:0] d;
    acc_host_model_i.read_reg(a, d);
    check("rdata", d, e);
  endtask
  task automatic pop(logic [35:0] e);
    logic [35:0] d;
    logic        v;
    acc_host_model_i.pop(d, v);
    check("pop valid", v, 1'b1);
    check("pop data", d, e);
  endtask
  // Back-to-back one-cycle samples, then a settling cycle.
  task automatic push(int n, logic [35:0] b);
    for (int i = 0; i < n; i++) begin
      cyc(1);
      sample_valid = 1'b1;
      sample_data = b + 36'(i);
    end
    cyc(1);
    sample_valid = 1'b0;
    sample_data = ~sample_data;
    cyc(1);
  endtask
  task automatic ticks(int n);
    for (int i = 0; i < n; i++) begin
      cyc(1);
      odr_tick = 1'b1;
      cyc(1);
      odr_tick = 1'b0;
    end
    cyc(2);
  endtask
  // Passing through standby flushes, then wake comes up.
  task automatic go_active(logic [7:0] aslp);
    op_mode = OP_STANDBY;
    cyc(2);
    auto_sleep_count = aslp;
    op_mode = OP_ACTIVE;
    cyc(2);
  endtask

  // Watchdog: the whole sequence needs well under 3000 cycles.
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    give_verdict();
  end

  initial begin
    clk_sys = 1'b0;
    nrst = 1'b0;
    op_mode = OP_STANDBY;
    auto_sleep_count = 8'h00;
    odr_tick = 1'b0;
    wake_request = 1'b0;
    sleep_block = 1'b0;
    trig_events = '0;
    sample_valid = 1'b0;
    sample_data = 36'h0;
    errors = 0;
    checks_done = 0;
    repeat (2) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    check("power", power_mode, PWR_STANDBY);
    rd(8'h26, 8'h00);
    rd(8'h27, 8'h00);
    // Register table rows: write, then read back.
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    // Stream mode, FIFO order, flush command and pointer restart.
    wr(8'h26, 8'h20);
    go_active(8'h00);
    check("power", power_mode, PWR_WAKE);
    push(3, 36'h100);
    check("count", sample_count, 6'h03);
    pop(36'h100);
    wr(8'h27, 8'h80);
    check("count", sample_count, 6'h00);
    rd(8'h27, 8'h00);
    push(1, 36'h200);
    pop(36'h200);
    push(33, 36'h400);
    check("count", sample_count, 6'h20);
    pop(36'h401);
    // Stop mode keeps the oldest, then disabling clears everything.
    wr(8'h26, 8'h40);
    wr(8'h27, 8'h84);
    push(34, 36'h500);
    check("ovf", overflow_flag, 1'b1);
    pop(36'h500);
    wr(8'h26, 8'h00);
    check("count", sample_count, 6'h00);
    check("ovf", overflow_flag, 1'b0);
    check("wm", watermark_flag, 1'b0);
    // Leaving standby flushes stored samples.
    wr(8'h26, 8'h20);
    push(2, 36'h600);
    check("count", sample_count, 6'h02);
    op_mode = OP_STANDBY;
    cyc(2);
    op_mode = OP_EXTERNAL_TRIGGER_MODE;
    cyc(2);
    check("count", sample_count, 6'h00);
    // Gate off: the wake to sleep change flushes.
    go_active(8'h02);
    push(2, 36'h700);
    check("count", sample_count, 6'h02);
    ticks(2);
    check("power", power_mode, PWR_SLEEP);
    check("count", sample_count, 6'h00);
    // Gate on: contents kept, later samples discarded and counted.
    wr(8'h26, 8'h30);
    go_active(8'h02);
    push(2, 36'h800);
    ticks(2);
    check("count", sample_count, 6'h02);
    push(3, 36'h900);
    check("count", sample_count, 6'h02);
    check("gate err", gate_err, 1'b1);
    check("gate cnt", gate_cnt, 5'h03);
    rd(8'h14, 8'h8e);
    pop(36'h800);
    check("gate err", gate_err, 1'b1);
    wr(8'h27, 8'h80);
    check("gate err", gate_err, 1'b0);
    check("gate cnt", gate_cnt, 5'h00);
    push(1, 36'ha00);
    check("count", sample_count, 6'h01);
    // An event holding the part awake keeps it out of sleep.
    sleep_block = 1'b1;
    go_active(8'h02);
    ticks(3);
    check("power", power_mode, PWR_WAKE);
    sleep_block = 1'b0;
    // Triggered capture with auto-sleep; gate bit set but ignored.
    wr(8'h27, 8'h04);
    wr(8'h26, 8'h79);
    go_active(8'h02);
    check("power", power_mode, PWR_WAKE);
    push(2, 36'hb00);
    ticks(2);
    check("power", power_mode, PWR_SLEEP);
    check("count", sample_count, 6'h00);
    push(6, 36'hc00);
    check("count", sample_count, 6'h04);
    check("wm", watermark_flag, 1'b1);
    check("gate err", gate_err, 1'b0);
    trig_events.within_thresh = 1'b1;
    cyc(1);
    trig_events.within_thresh = 1'b0;
    cyc(1);
    check("power", power_mode, PWR_WAKE);
    push(29, 36'hd00);
    check("count", sample_count, 6'h20);
    check("ovf", overflow_flag, 1'b1);
    rd(8'h0b, 8'he0);
    trig_events.orientation = 1'b1;
    cyc(1);
    trig_events.orientation = 1'b0;
    ticks(3);
    check("power", power_mode, PWR_WAKE);
    pop(36'hc02);
    // Rest of the capture: pre-trigger tail, then the post-trigger run.
    for (int i = 0; i < 31; i++) begin
      pop(i < 3 ? 36'hc03 + 36'(i) : 36'hd00 + 36'(i - 3));
    end
    cyc(1);
    check("count", sample_count, 6'h00);
    check("ovf", overflow_flag, 1'b0);
    // A trigger while still awake must not start a second capture.
    trig_events.within_thresh = 1'b1;
    cyc(1);
    trig_events.within_thresh = 1'b0;
    ticks(2);
    check("power", power_mode, PWR_SLEEP);
    // A mid-run reset returns power and configuration to their defaults.
    nrst = 1'b0;
    cyc(1);
    check("power", power_mode, PWR_STANDBY);
    nrst = 1'b1;
    cyc(2);
    rd(8'h26, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
